//--- verilog/drs_top.sv
// debug reset, strap sampling and debug unit reset control
//
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module drs_top #(
    parameter int FIFO_W = 8
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic power_on_reset_pin_n,
    input wire logic manual_reset_pin_n,
    input wire logic link_input_data_strap,
    input wire logic link_input_clock_strap,
    input wire logic link_input_sync_strap,
    input wire logic trst_n,
    input wire logic jtag_debug_loaded,
    input wire logic du_fifo_push,
    input wire logic du_fifo_pop,
    input wire logic du_capture,
    input wire logic du_irq_event,
    input wire logic du_stall_req,
    input wire logic wp_hit,
    input wire logic timing_event,
    input wire logic trace_overflow,
    input wire logic trigger_in_pin_n,
    output logic trigger_out_pin_n,
    output logic wp_trigger,
    output logic tap_reset,
    output logic chip_reset,
    output logic debug_regs_reset,
    output logic [1:0] reset_kind,
    output logic cpu_debug_vector_sel,
    output logic cpu_suspend,
    output logic debug_unit_enable,
    output logic debug_unit_clk_en,
    output logic link_jtag_sel,
    output logic du_irq,
    output logic du_stall,
    output logic [FIFO_W-1:0] du_fifo_level
);
    localparam logic [7:0] SW_CYC = 8'(drs_pkg::DRS_SW_RST_CYC - 1);

    typedef struct packed {
        drs_pkg::drs_st_e st;
        drs_pkg::drs_kind_e kind;
        logic [7:0] cnt;
        logic rst;
        logic dreg_rst;
        logic jtag;
        logic vec_req;
        logic vec_dbg;
        logic [1:0] tsel;
        logic tout_en;
        logic tin_en;
        logic [FIFO_W-1:0] fifo;
        logic cap;
        logic irq;
        logic stall;
        logic [31:0] rdata;
    } drs_state_s;

    drs_state_s q, d;
    logic pins_low;
    logic capture;
    logic release_req;
    logic du_en;
    logic susp;
    logic wr_ctrl;
    logic wr_trig;
    logic du_clear;

    assign pins_low = ~power_on_reset_pin_n | ~manual_reset_pin_n;
    assign wr_ctrl = wr && addr == drs_pkg::DRS_CTRL_OFS;
    assign wr_trig = wr && addr == drs_pkg::DRS_TRIG_OFS;
    assign release_req = wr_ctrl & wdata[drs_pkg::DRS_CTRL_RELEASE];

    // reset sequencer, register file and debug unit internal state
    always_comb begin
        d = q;
        d.rdata = '0;
        d.dreg_rst = 1'b0;
        capture = 1'b0;
        case (q.st)
            drs_pkg::DRS_ST_IDLE: begin
                if (pins_low) begin
                    d.st = drs_pkg::DRS_ST_PIN;
                    d.rst = 1'b1;
                    if (!link_input_data_strap) begin
                        d.kind = drs_pkg::DRS_KIND_DEBUG;
                    end else if (!power_on_reset_pin_n) begin
                        d.kind = drs_pkg::DRS_KIND_POR;
                    end else begin
                        d.kind = drs_pkg::DRS_KIND_MANUAL;
                    end
                end else if (wr_ctrl && wdata[drs_pkg::DRS_CTRL_DBG_RST]) begin
                    d.st = drs_pkg::DRS_ST_SW;
                    d.rst = 1'b1;
                    d.cnt = SW_CYC;
                    d.kind = drs_pkg::DRS_KIND_DEBUG;
                end else if (wr_ctrl && wdata[drs_pkg::DRS_CTRL_CPU_RST]) begin
                    d.st = drs_pkg::DRS_ST_SW;
                    d.rst = 1'b1;
                    d.cnt = SW_CYC;
                    d.kind = drs_pkg::DRS_KIND_CPU;
                    d.vec_req = wdata[drs_pkg::DRS_CTRL_VEC_REQ];
                end
            end
            drs_pkg::DRS_ST_PIN: begin
                // the data strap is watched for the whole pin hold
                if (!link_input_data_strap) begin
                    d.kind = drs_pkg::DRS_KIND_DEBUG;
                end
                if (!pins_low) begin
                    d.st = drs_pkg::DRS_ST_IDLE;
                    capture = 1'b1;
                end
            end
            drs_pkg::DRS_ST_SW: begin
                // a pin reset overrides a running software reset
                if (pins_low) begin
                    d.st = drs_pkg::DRS_ST_PIN;
                    d.kind = link_input_data_strap ?
                        (power_on_reset_pin_n ? drs_pkg::DRS_KIND_MANUAL
                                              : drs_pkg::DRS_KIND_POR)
                        : drs_pkg::DRS_KIND_DEBUG;
                end else if (q.cnt == 8'h00) begin
                    d.st = drs_pkg::DRS_ST_IDLE;
                    capture = 1'b1;
                end else begin
                    d.cnt = q.cnt - 8'h01;
                end
            end
            default: begin
                d.st = drs_pkg::DRS_ST_IDLE;
            end
        endcase

        // actions at the release edge of any reset
        if (capture) begin
            d.rst = 1'b0;
            d.vec_dbg = (q.kind == drs_pkg::DRS_KIND_CPU) & q.vec_req;
            d.vec_req = 1'b0;
            if (q.kind == drs_pkg::DRS_KIND_POR || q.kind == drs_pkg::DRS_KIND_MANUAL) begin
                // full reset: debug registers and link selection return to default
                d.dreg_rst = 1'b1;
                d.jtag = 1'b0;
                d.tsel = drs_pkg::DRS_TRIG_SEL_RST;
                d.tout_en = 1'b0;
                d.tin_en = 1'b0;
            end
            // a debug reset keeps jtag, tsel and trigger enables
        end

        // jtag selection sticks until a full reset; set wins over clear
        if (jtag_debug_loaded) begin
            d.jtag = 1'b1;
        end

        // trigger configuration write
        if (wr_trig) begin
            d.tsel = wdata[drs_pkg::DRS_TRIG_SEL_LO +: 2];
            d.tout_en = wdata[drs_pkg::DRS_TRIG_OUT_EN];
            d.tin_en = wdata[drs_pkg::DRS_TRIG_IN_EN];
        end

        // debug unit internal state, held cleared through non-cpu resets
        if (du_clear) begin
            d.fifo = '0;
            d.cap = 1'b0;
            d.irq = 1'b0;
            d.stall = 1'b0;
        end else begin
            if (du_fifo_push && !du_fifo_pop && q.fifo != '1) begin
                d.fifo = q.fifo + 1'b1;
            end else if (du_fifo_pop && !du_fifo_push && q.fifo != '0) begin
                d.fifo = q.fifo - 1'b1;
            end
            if (du_capture) begin
                d.cap = 1'b1;
            end
            if (du_irq_event) begin
                d.irq = 1'b1;
            end
            d.stall = du_stall_req;
        end

        // read data, valid the cycle after the strobe
        if (rd) begin
            case (addr)
                drs_pkg::DRS_TRIG_OFS: begin
                    d.rdata[drs_pkg::DRS_TRIG_SEL_LO +: 2] = q.tsel;
                    d.rdata[drs_pkg::DRS_TRIG_OUT_EN] = q.tout_en;
                    d.rdata[drs_pkg::DRS_TRIG_IN_EN] = q.tin_en;
                end
                drs_pkg::DRS_STAT_OFS: begin
                    d.rdata[drs_pkg::DRS_STAT_KIND_LO +: 2] = q.kind;
                    d.rdata[drs_pkg::DRS_STAT_DU_EN] = du_en;
                    d.rdata[drs_pkg::DRS_STAT_SUSP] = susp;
                    d.rdata[drs_pkg::DRS_STAT_JTAG] = q.jtag;
                    d.rdata[drs_pkg::DRS_STAT_VEC] = q.vec_dbg;
                end
                drs_pkg::DRS_DUST_OFS: begin
                    d.rdata[FIFO_W-1:0] = q.fifo;
                    d.rdata[drs_pkg::DRS_DUST_CAP] = q.cap;
                    d.rdata[drs_pkg::DRS_DUST_IRQ] = q.irq;
                    d.rdata[drs_pkg::DRS_DUST_STALL] = q.stall;
                end
                default: begin
                    d.rdata = '0;
                end
            endcase
        end
    end

    // debug unit is cleared while any reset other than a cpu reset runs
    assign du_clear = q.rst & (q.kind != drs_pkg::DRS_KIND_CPU);

    // state register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            q <= '{st: drs_pkg::DRS_ST_IDLE, kind: drs_pkg::DRS_KIND_POR,
                   tsel: drs_pkg::DRS_TRIG_SEL_RST, default: '0};
        end else begin
            q <= d;
        end
    end

    // strap capture and cpu suspend hold
    drs_strap_latch u_strap (
        .clk(clk),
        .rstn(rstn),
        .capture(capture),
        .release_req(release_req),
        .clk_strap(link_input_clock_strap),
        .sync_strap(link_input_sync_strap),
        .du_enable(du_en),
        .cpu_suspend(susp)
    );

    // trigger pins
    drs_trigger u_trig (
        .clk(clk),
        .rstn(rstn),
        .src_sel(q.tsel),
        .out_en(q.tout_en),
        .in_en(q.tin_en),
        .wp_hit(wp_hit),
        .timing_event(timing_event),
        .trace_overflow(trace_overflow),
        .trigger_in_pin_n(trigger_in_pin_n),
        .trigger_out_pin_n(trigger_out_pin_n),
        .wp_trigger(wp_trigger)
    );

    // outputs
    assign tap_reset = ~trst_n; // nothing else looks at trst_n
    assign rdata = q.rdata;
    assign chip_reset = q.rst;
    assign debug_regs_reset = q.dreg_rst;
    assign reset_kind = q.kind;
    assign cpu_debug_vector_sel = q.vec_dbg;
    assign cpu_suspend = susp;
    assign debug_unit_enable = du_en;
    assign debug_unit_clk_en = du_en;
    assign link_jtag_sel = q.jtag;
    assign du_irq = q.irq;
    assign du_stall = q.stall;
    assign du_fifo_level = q.fifo;
endmodule // drs_top
`default_nettype wire

//--- verilog/drs_pkg.sv
// constants and types shared by the debug reset and strap control block
`default_nettype none
package drs_pkg;
    // register byte offsets
    localparam logic [3:0] DRS_CTRL_OFS = 4'h0;
    localparam logic [3:0] DRS_TRIG_OFS = 4'h4;
    localparam logic [3:0] DRS_STAT_OFS = 4'h8;
    localparam logic [3:0] DRS_DUST_OFS = 4'hc;
    // control action register fields (write pulses)
    localparam int DRS_CTRL_CPU_RST = 0;
    localparam int DRS_CTRL_DBG_RST = 1;
    localparam int DRS_CTRL_RELEASE = 2;
    localparam int DRS_CTRL_VEC_REQ = 3;
    // trigger configuration fields
    localparam int DRS_TRIG_SEL_LO = 0;
    localparam int DRS_TRIG_OUT_EN = 2;
    localparam int DRS_TRIG_IN_EN = 3;
    localparam logic [1:0] DRS_TRIG_SEL_RST = 2'h0;
    // status register fields
    localparam int DRS_STAT_KIND_LO = 0;
    localparam int DRS_STAT_DU_EN = 2;
    localparam int DRS_STAT_SUSP = 3;
    localparam int DRS_STAT_JTAG = 4;
    localparam int DRS_STAT_VEC = 5;
    // debug unit state register fields
    localparam int DRS_DUST_CAP = 8;
    localparam int DRS_DUST_IRQ = 9;
    localparam int DRS_DUST_STALL = 10;
    // software reset hold time
    localparam int DRS_CLK_PERIOD_PS = 4000;
    localparam int DRS_SW_RST_NS = 64;
    localparam int DRS_SW_RST_CYC =
        (DRS_SW_RST_NS * 1000 + DRS_CLK_PERIOD_PS - 1) / DRS_CLK_PERIOD_PS;
    // trigger output sources
    typedef enum logic [1:0] {
        DRS_TSRC_WP = 2'h0,
        DRS_TSRC_TIMING = 2'h1,
        DRS_TSRC_OVF = 2'h2,
        DRS_TSRC_TRIGIN = 2'h3
    } drs_tsrc_e;
    // kind of reset last performed
    typedef enum logic [1:0] {
        DRS_KIND_POR = 2'h0,
        DRS_KIND_MANUAL = 2'h1,
        DRS_KIND_DEBUG = 2'h2,
        DRS_KIND_CPU = 2'h3
    } drs_kind_e;
    // sequencer states
    typedef enum logic [1:0] {
        DRS_ST_IDLE = 2'h0,
        DRS_ST_PIN = 2'h1,
        DRS_ST_SW = 2'h2
    } drs_st_e;
endpackage : drs_pkg
`default_nettype wire

//--- verilog/drs_strap_latch.sv
// strap capture at reset release and cpu suspend hold
`timescale 1ns/1ps
`default_nettype none
module drs_strap_latch (
    input wire logic clk,
    input wire logic rstn,
    input wire logic capture,
    input wire logic release_req,
    input wire logic clk_strap,
    input wire logic sync_strap,
    output logic du_enable,
    output logic cpu_suspend
);
    typedef struct packed {
        logic du_en;
        logic susp;
    } drs_latch_s;

    drs_latch_s q, d;

    // straps sampled only on the release edge, held until next release or, for suspend, a release write
    always_comb begin
        d = q;
        if (release_req) begin
            d.susp = 1'b0;
        end
        if (capture) begin
            d.du_en = ~clk_strap;
            d.susp = ~sync_strap;
        end
    end

    // register the state
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign du_enable = q.du_en;
    assign cpu_suspend = q.susp;
endmodule // drs_strap_latch
`default_nettype wire

//--- verilog/drs_trigger.sv
// trigger input qualifier and trigger output source select
`timescale 1ns/1ps
`default_nettype none
module drs_trigger (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [1:0] src_sel,
    input wire logic out_en,
    input wire logic in_en,
    input wire logic wp_hit,
    input wire logic timing_event,
    input wire logic trace_overflow,
    input wire logic trigger_in_pin_n,
    output logic trigger_out_pin_n,
    output logic wp_trigger
);
    typedef struct packed {
        logic out_n;
        logic trig;
    } drs_trig_s;

    drs_trig_s q, d;
    logic src;

    // pick the event shown on the trigger output
    always_comb begin
        case (drs_pkg::drs_tsrc_e'(src_sel))
            drs_pkg::DRS_TSRC_WP: src = wp_hit;
            drs_pkg::DRS_TSRC_TIMING: src = timing_event;
            drs_pkg::DRS_TSRC_OVF: src = trace_overflow;
            drs_pkg::DRS_TSRC_TRIGIN: src = ~trigger_in_pin_n;
            default: src = 1'b0;
        endcase
        d.out_n = ~(out_en & src);
        d.trig = in_en & ~trigger_in_pin_n;
    end

    // register the pins; output idles high
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            q <= '{out_n: 1'b1, trig: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign trigger_out_pin_n = q.out_n;
    assign wp_trigger = q.trig;
endmodule // drs_trigger
`default_nettype wire

//--- tb/drs_top_monitor.sv
// assertion checker for the debug reset and strap control block
`timescale 1ns/1ps
`default_nettype none
module drs_top_monitor #(
    parameter int FIFO_W = 8
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic power_on_reset_pin_n,
    input wire logic manual_reset_pin_n,
    input wire logic link_input_data_strap,
    input wire logic link_input_clock_strap,
    input wire logic link_input_sync_strap,
    input wire logic trst_n,
    input wire logic jtag_debug_loaded,
    input wire logic tap_reset,
    input wire logic chip_reset,
    input wire logic debug_regs_reset,
    input wire logic [1:0] reset_kind,
    input wire logic cpu_debug_vector_sel,
    input wire logic cpu_suspend,
    input wire logic debug_unit_enable,
    input wire logic debug_unit_clk_en,
    input wire logic link_jtag_sel,
    input wire logic du_irq,
    input wire logic du_stall,
    input wire logic [FIFO_W-1:0] du_fifo_level
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // control write and pin reset decode
    wire logic ctrl_wr = wr && addr == drs_pkg::DRS_CTRL_OFS;
    wire logic pin_lo = !power_on_reset_pin_n || !manual_reset_pin_n;
    wire logic dbg_end = chip_reset == 1'b0 && reset_kind == drs_pkg::DRS_KIND_DEBUG;

    a_tap_reset_only: assert property (tap_reset == !trst_n)
        else $error("tap reset does not follow trst");
    a_debug_kind: assert property (pin_lo && !link_input_data_strap
        |=> reset_kind == drs_pkg::DRS_KIND_DEBUG)
        else $error("data strap low did not give debug reset");
    a_vector_ordinary: assert property ($fell(chip_reset) && dbg_end
        |-> !cpu_debug_vector_sel)
        else $error("debug reset left via debug vector");
    a_regs_kept: assert property (debug_regs_reset |-> reset_kind inside
        {drs_pkg::DRS_KIND_POR, drs_pkg::DRS_KIND_MANUAL})
        else $error("debug registers reset outside por or manual");
    a_regs_full_reset: assert property ($fell(chip_reset) && reset_kind inside
        {drs_pkg::DRS_KIND_POR, drs_pkg::DRS_KIND_MANUAL} |-> debug_regs_reset)
        else $error("debug registers not reset after por or manual");
    a_du_cleared: assert property ($fell(chip_reset) && dbg_end
        |-> du_fifo_level == '0 && !du_irq && !du_stall)
        else $error("debug unit state not cleared");
    a_enable_sample: assert property ($fell(chip_reset) |->
        debug_unit_enable == !link_input_clock_strap && debug_unit_clk_en == debug_unit_enable)
        else $error("debug unit enable not taken from clock strap");
    a_suspend_sample: assert property ($fell(chip_reset) |->
        cpu_suspend == !link_input_sync_strap)
        else $error("suspend not taken from sync strap");
    a_straps_held: assert property (!chip_reset && !$fell(chip_reset)
        |-> $stable(debug_unit_enable))
        else $error("debug unit enable changed outside reset");
    a_suspend_held: assert property (cpu_suspend && !chip_reset && !ctrl_wr
        |=> cpu_suspend || chip_reset)
        else $error("suspend dropped without release");
    a_release_write: assert property (cpu_suspend && !chip_reset && !pin_lo && ctrl_wr
        && wdata[drs_pkg::DRS_CTRL_RELEASE] |=> !cpu_suspend)
        else $error("release write did not end suspend");
    a_jtag_select: assert property (jtag_debug_loaded |=> link_jtag_sel)
        else $error("jtag link not selected");
    a_link_kept: assert property (link_jtag_sel && reset_kind == drs_pkg::DRS_KIND_DEBUG
        |=> link_jtag_sel)
        else $error("debug reset changed the link");
    c_debug_end: cover property ($fell(chip_reset) && dbg_end);
    c_jtag_load: cover property (jtag_debug_loaded);
    c_release: cover property (cpu_suspend && ctrl_wr);
endmodule // drs_top_monitor
bind drs_top drs_top_monitor #(.FIFO_W(FIFO_W)) mon_u (.*);
`default_nettype wire

//--- tb/drs_tool_model.sv
// behavioural debug tool driving reset pins and straps
`timescale 1ns/1ps
`default_nettype none
module drs_tool_model (
    input wire logic clk,
    output logic power_on_reset_pin_n,
    output logic manual_reset_pin_n,
    output logic link_input_data_strap,
    output logic link_input_clock_strap,
    output logic link_input_sync_strap,
    output logic trst_n
);
    // idle: pulled-up straps high, link clock standing still
    initial begin
        power_on_reset_pin_n = 1'b1;
        manual_reset_pin_n = 1'b1;
        link_input_data_strap = 1'b1;
        link_input_clock_strap = 1'b0;
        link_input_sync_strap = 1'b1;
        trst_n = 1'b1;
    end
    // board reset pulled low for six cycles while the straps are driven to the given values
    task automatic pin_reset(input logic man, input logic dat, input logic late,
                             input logic cs, input logic ss);
        @(posedge clk);
        power_on_reset_pin_n <= man;
        manual_reset_pin_n <= !man;
        link_input_data_strap <= dat;
        link_input_clock_strap <= cs;
        link_input_sync_strap <= ss;
        repeat (3) @(posedge clk);
        if (late) link_input_data_strap <= 1'b0;
        repeat (3) @(posedge clk);
        power_on_reset_pin_n <= 1'b1;
        manual_reset_pin_n <= 1'b1;
        repeat (3) @(posedge clk);
        link_input_data_strap <= 1'b1;
        link_input_clock_strap <= 1'b0;
        link_input_sync_strap <= 1'b1;
    endtask
    // tap reset line
    task automatic set_trst(input logic v);
        @(posedge clk);
        trst_n <= v;
    endtask
endmodule // drs_tool_model
`default_nettype wire

//--- tb/drs_top_tb.sv
// self-checking bench for the debug reset and strap control block
`timescale 1ns/1ps
`default_nettype none
module drs_top_tb;
    logic clk, rstn, wr, rd, trst_n, jtag_debug_loaded, du_fifo_push, du_fifo_pop;
    logic du_capture, du_irq_event, du_stall_req, wp_hit, timing_event, trace_overflow;
    logic trigger_in_pin_n, power_on_reset_pin_n, manual_reset_pin_n;
    logic link_input_data_strap, link_input_clock_strap, link_input_sync_strap;
    logic trigger_out_pin_n, wp_trigger, tap_reset, chip_reset, debug_regs_reset;
    logic cpu_debug_vector_sel, cpu_suspend, debug_unit_enable, debug_unit_clk_en;
    logic link_jtag_sel, du_irq, du_stall;
    logic [1:0] reset_kind;
    logic [3:0] addr;
    logic [31:0] wdata, rdata;
    logic [7:0] du_fifo_level;
    int bad_count, check_count;

    drs_top dut_u (.*);
    drs_tool_model tool_u (.*);

    // clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    // bounded wait for the reset sequence to end, counting its cycles
    task automatic wait_idle(output int n);
        n = 0;
        #1;
        while (chip_reset === 1'b1 && n < 200) begin
            @(posedge clk);
            #1 n++;
        end
    endtask
    task automatic t_por_suspend();
        int n;
        tool_u.pin_reset(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
        wait_idle(n);
        rd_reg(drs_pkg::DRS_STAT_OFS, 32'h0000000c);
        chk(cpu_suspend, 1'b1);
        wr_reg(drs_pkg::DRS_CTRL_OFS, 32'h4);
        #1 chk(cpu_suspend, 1'b0);
    endtask
    task automatic t_manual_debug();
        int n;
        tool_u.pin_reset(1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
        wait_idle(n);
        chk({reset_kind, debug_unit_clk_en}, 3'b010);
        tool_u.pin_reset(1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
        wait_idle(n);
        chk({reset_kind, debug_unit_enable}, 3'b101);
        tool_u.pin_reset(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
        wait_idle(n);
        chk(reset_kind, drs_pkg::DRS_KIND_DEBUG);
    endtask
    task automatic t_sw_debug();
        int n;
        @(posedge clk);
        {jtag_debug_loaded, du_fifo_push, du_capture, du_irq_event, du_stall_req} <= 5'h1f;
        repeat (3) @(posedge clk);
        {jtag_debug_loaded, du_fifo_push, du_capture, du_irq_event, du_fifo_pop} <= 5'h01;
        @(posedge clk);
        du_fifo_pop <= 1'b0;
        wr_reg(drs_pkg::DRS_TRIG_OFS, 32'h6);
        rd_reg(drs_pkg::DRS_DUST_OFS, 32'h00000702);
        chk({du_irq, du_stall, du_fifo_level}, {2'b11, 8'h02});
        @(posedge clk);
        du_stall_req <= 1'b0;
        wr_reg(drs_pkg::DRS_CTRL_OFS, 32'h2);
        wait_idle(n);
        chk(n, 16);
        rd_reg(drs_pkg::DRS_DUST_OFS, 32'h0);
        chk({du_irq, du_stall, du_fifo_level}, 10'h000);
        rd_reg(drs_pkg::DRS_TRIG_OFS, 32'h6);
        rd_reg(drs_pkg::DRS_STAT_OFS, 32'h00000016);
        tool_u.pin_reset(1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
        wait_idle(n);
        chk(link_jtag_sel, 1'b0);
        rd_reg(drs_pkg::DRS_TRIG_OFS, 32'h0);
    endtask
    task automatic t_cpu_reset();
        int n;
        wr_reg(drs_pkg::DRS_CTRL_OFS, 32'h9);
        wait_idle(n);
        chk({reset_kind, cpu_debug_vector_sel}, 3'b111);
        wr_reg(drs_pkg::DRS_CTRL_OFS, 32'hb);
        wait_idle(n);
        chk({reset_kind, cpu_debug_vector_sel}, 3'b100);
    endtask
    task automatic t_trst_regs();
        tool_u.set_trst(1'b0);
        #1 chk({tap_reset, chip_reset}, 2'b10);
        rd_reg(4'h2, 32'h0);
        rd_reg(drs_pkg::DRS_CTRL_OFS, 32'h0);
        wr_reg(drs_pkg::DRS_STAT_OFS, 32'hffffffff);
        rd_reg(drs_pkg::DRS_STAT_OFS, 32'h00000006);
        tool_u.set_trst(1'b1);
        #1 chk(tap_reset, 1'b0);
    endtask
    task automatic t_trigger();
        logic [3:0] act;
        for (int s = 0; s < 5; s++) begin
            wr_reg(drs_pkg::DRS_TRIG_OFS, (s < 4) ? (32'(s) | 32'hc) : 32'h0);
            act = 4'h1 << (s % 4);
            @(posedge clk);
            {trigger_in_pin_n, trace_overflow, timing_event, wp_hit} <= act ^ 4'h8;
            repeat (3) @(posedge clk);
            #1 chk({trigger_out_pin_n, wp_trigger}, {s == 4, s == 3});
            @(posedge clk);
            {trigger_in_pin_n, trace_overflow, timing_event, wp_hit} <= 4'h8;
            repeat (3) @(posedge clk);
            #1 chk(trigger_out_pin_n, 1'b1);
        end
    endtask
    task automatic end_of_test();
        if (bad_count == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // watchdog
    initial begin
        #40000;
        bad_count++;
        end_of_test();
    end
    // main sequence
    initial begin
        rstn = 1'b0;
        {wr, rd, jtag_debug_loaded, du_fifo_push, du_fifo_pop, du_capture} = 6'h0;
        {du_irq_event, du_stall_req, wp_hit, timing_event, trace_overflow} = 5'h0;
        trigger_in_pin_n = 1'b1;
        addr = 4'h0;
        wdata = 32'h0;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        t_por_suspend();
        t_manual_debug();
        t_sw_debug();
        t_cpu_reset();
        t_trst_regs();
        t_trigger();
        end_of_test();
    end
endmodule // drs_top_tb
`default_nettype wire
